// [rtl/peb_pkg.sv]
// Constants, field layouts and carrier types for the strap override and boost register slice.
// Assumes one device clock at 40 MHz and a simple byte-wide register port driven by the serial front end.
package peb_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_RSVD_RO_A = 8'h39;
  localparam logic [7:0] ADDR_LOW_RATE_BOOST = 8'h3A;
  localparam logic [7:0] ADDR_RSVD_RO_B = 8'h3B;
  localparam logic [7:0] ADDR_RSVD_RO_C = 8'h3C;
  localparam logic [7:0] ADDR_RSVD_RW_D = 8'h3D;
  localparam logic [7:0] ADDR_EYE_LOCK_MON = 8'h3E;
  localparam logic [7:0] ADDR_STRAP_OVERRIDE = 8'h3F;
  localparam logic [7:0] ADDR_ADAPT_ENTRY0 = 8'h40;
  localparam logic [7:0] ADDR_ADAPT_ENTRY1 = 8'h41;
  localparam logic [7:0] ADDR_ADAPT_ENTRY2 = 8'h42;
  localparam logic [7:0] ADDR_ADAPT_ENTRY3 = 8'h43;

  // Values after reset
  localparam logic [7:0] RST_RSVD_RO_A = 8'h00;
  localparam logic [7:0] RST_LOW_RATE_BOOST = 8'h00;
  localparam logic [7:0] RST_RSVD_RO_B = 8'h96;
  localparam logic [7:0] RST_RSVD_RO_C = 8'h90;
  localparam logic [7:0] RST_RSVD_RW_D = 8'h00;
  localparam logic [7:0] RST_EYE_LOCK_MON = 8'h80;
  localparam logic [7:0] RST_STRAP_OVERRIDE = 8'h01;
  localparam logic [7:0] RST_ADAPT_ENTRY0 = 8'h00;
  localparam logic [7:0] RST_ADAPT_ENTRY1 = 8'h40;
  localparam logic [7:0] RST_ADAPT_ENTRY2 = 8'h80;
  localparam logic [7:0] RST_ADAPT_ENTRY3 = 8'h50;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // Bit positions
  localparam int LOCKMON_EN_BIT = 7;
  localparam int ADAPT_STRAP_BYPASS_BIT = 5;
  localparam int INSEL_STRAP_BYPASS_BIT = 4;
  localparam int OUTMUX_STRAP_BYPASS_BIT = 3;
  localparam int REFRATE_STRAP_BYPASS_BIT = 2;
  localparam int BOOST_STRAP_BYPASS_BIT = 1;
  localparam int MID_RATE_ADAPT_BIT = 0;

  // Field encodings
  localparam logic [1:0] ROUTE_FIRST_BOTH = 2'h0;
  localparam logic [1:0] ROUTE_FIRST_OUT0 = 2'h1;
  localparam logic [1:0] ROUTE_SECOND_OUT1 = 2'h2;
  localparam logic [1:0] ROUTE_SECOND_BOTH = 2'h3;
  localparam logic [1:0] MODE_MANUAL = 2'h0;
  localparam logic [1:0] MODE_AUTO = 2'h1;
  localparam logic [1:0] REFRATE_VIDEO = 2'h0;
  localparam logic [1:0] REFRATE_10GBE = 2'h1;
  localparam logic [1:0] STRAP_INSEL_10GBE = 2'h3;
  localparam logic [1:0] STRAP_OUTCTRL_BYPASS = 2'h3;

  // Eye monitor interval base time and its cycle count
  localparam int CLK_MHZ = 40;
  localparam int EYE_BASE_US = 25;
  localparam int EYE_BASE_CYCLES = EYE_BASE_US * CLK_MHZ;

  // Detected line rate
  typedef enum logic [2:0] {
    RATE_270M,
    RATE_1G5,
    RATE_3G,
    RATE_6G,
    RATE_12G,
    RATE_10GBE,
    RATE_NONE
  } peb_rate_t;

  // One boost byte as four stage controls
  typedef struct packed {
    logic [1:0] stage0;
    logic [1:0] stage1;
    logic [1:0] stage2;
    logic [1:0] stage3;
  } peb_boost_t;

  // Fields held in neighbouring registers
  typedef struct packed {
    logic [1:0] adapt_mode;
    logic [1:0] route_sel;
    logic [1:0] out_mux;
    logic [1:0] ref_rate;
    logic boost_ov_en;
    logic [7:0] boost_word;
    logic [3:0] eye_interval;
  } peb_ext_t;

  // Resolved control outputs
  typedef struct packed {
    logic out0_on;
    logic out1_on;
    logic src_second;
    logic [1:0] out_mux;
    logic [1:0] ref_rate;
    logic ref_rate_invalid;
    logic adapt_en;
    logic boost_bypass;
  } peb_ctrl_t;

endpackage

// [rtl/peb_sync.sv]
// Two-stage synchroniser for a bus of levels.
// Assumes the input bits change slowly, as straps do; no multi-bit coherence is given.
`timescale 1ns/1ps
module peb_sync #(
  parameter int W = 1
) (
  input wire logic clk, // Sampling clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [W-1:0] d, // Asynchronous level
  output logic [W-1:0] q // Synchronised level
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;

endmodule

// [rtl/peb_top.sv]
// Strap override, low-rate boost, eye lock monitor and boost table registers.
// Assumes a byte register port from the serial front end and neighbouring fields on the same clock.
`timescale 1ns/1ps
module peb_top #(
  parameter int EYE_BASE_CYCLES = peb_pkg::EYE_BASE_CYCLES
) (
  input wire logic CLK, // Device clock
  input wire logic RSTN, // Async reset, active low
  input wire logic [7:0] REG_ADDR, // Register address
  input wire logic REG_WR, // Write strobe
  input wire logic REG_RD, // Read strobe
  input wire logic [7:0] REG_WDATA, // Write data
  output logic [7:0] REG_RDATA, // Read data
  output logic REG_RVALID, // Read data valid pulse
  input wire logic [1:0] IN_OUT_SEL_PIN, // Input/output select strap
  input wire logic [1:0] OUT_CTRL_PIN, // Output control strap
  input wire peb_pkg::peb_ext_t EXT_FIELDS, // Neighbouring register fields
  input wire peb_pkg::peb_rate_t RATE_DETECT, // Detected line rate
  input wire logic LOCK_DONE, // Clock recovery locked
  input wire logic ADAPT_DONE, // Adaptation finished
  input wire logic [1:0] ADAPT_INDEX, // Current adaptation index
  output peb_pkg::peb_ctrl_t CTRL_OUT, // Resolved controls
  output peb_pkg::peb_boost_t BOOST_STAGES, // Second-input equalizer stages
  output logic EYE_EVAL_PULSE, // Eye evaluation request
  output logic MONITOR_ACTIVE // Eye monitor running
);

  typedef enum logic [1:0] {
    EYE_IDLE,
    EYE_COUNT,
    EYE_FIRE
  } peb_eye_state_t;

  logic rst_meta_reg;
  logic rst_n_sync_reg;
  logic rst_n;
  logic [1:0] insel_pin;
  logic [1:0] outctrl_pin;

  logic [7:0] low_rate_boost_reg;
  logic [7:0] rsvd_rw_d_reg;
  logic [7:0] eye_lock_mon_reg;
  logic [7:0] strap_override_reg;
  logic [7:0] adapt_entry_reg [4];
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  peb_pkg::peb_ctrl_t ctrl_reg;
  peb_pkg::peb_ctrl_t ctrl_next;
  peb_pkg::peb_boost_t boost_reg;
  peb_pkg::peb_boost_t boost_next;
  peb_eye_state_t eye_state_reg;
  peb_eye_state_t eye_state_next;
  logic [31:0] eye_cnt_reg;
  logic [31:0] eye_cnt_next;
  logic eye_pulse_reg;
  logic mon_active_reg;

  // Reset release through two flip-flops
  // Only the second flop is read, so release never reaches logic metastable
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_n_sync_reg;

  // Strap pins into the clock domain
  peb_sync #(.W(4)) u_strap_sync (
    .clk(CLK),
    .rst_n(rst_n),
    .d({IN_OUT_SEL_PIN, OUT_CTRL_PIN}),
    .q({insel_pin, outctrl_pin})
  );

  // Address decode
  wire wr_low_rate = REG_WR && (REG_ADDR == peb_pkg::ADDR_LOW_RATE_BOOST);
  wire wr_rsvd_d = REG_WR && (REG_ADDR == peb_pkg::ADDR_RSVD_RW_D);
  wire wr_eye_mon = REG_WR && (REG_ADDR == peb_pkg::ADDR_EYE_LOCK_MON);
  wire wr_override = REG_WR && (REG_ADDR == peb_pkg::ADDR_STRAP_OVERRIDE);
  wire wr_entry_hit = REG_WR && (REG_ADDR[7:2] == peb_pkg::ADDR_ADAPT_ENTRY0[7:2]);
  wire [1:0] wr_entry_idx = REG_ADDR[1:0];

  // Override bit views
  wire mon_enable = eye_lock_mon_reg[peb_pkg::LOCKMON_EN_BIT];
  wire adapt_bypass = strap_override_reg[peb_pkg::ADAPT_STRAP_BYPASS_BIT];
  wire insel_bypass = strap_override_reg[peb_pkg::INSEL_STRAP_BYPASS_BIT];
  wire outmux_bypass = strap_override_reg[peb_pkg::OUTMUX_STRAP_BYPASS_BIT];
  wire refrate_bypass = strap_override_reg[peb_pkg::REFRATE_STRAP_BYPASS_BIT];
  wire boost_bypass_ov = strap_override_reg[peb_pkg::BOOST_STRAP_BYPASS_BIT];
  wire mid_rate_adapt = strap_override_reg[peb_pkg::MID_RATE_ADAPT_BIT];

  // Writable registers
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      low_rate_boost_reg <= peb_pkg::RST_LOW_RATE_BOOST;
      rsvd_rw_d_reg <= peb_pkg::RST_RSVD_RW_D;
      eye_lock_mon_reg <= peb_pkg::RST_EYE_LOCK_MON;
      strap_override_reg <= peb_pkg::RST_STRAP_OVERRIDE;
    end else begin
      if (wr_low_rate) low_rate_boost_reg <= REG_WDATA;
      if (wr_rsvd_d) rsvd_rw_d_reg <= REG_WDATA;
      if (wr_eye_mon) eye_lock_mon_reg <= REG_WDATA;
      if (wr_override) strap_override_reg <= REG_WDATA;
    end
  end

  // Boost table entries
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      adapt_entry_reg[0] <= peb_pkg::RST_ADAPT_ENTRY0;
      adapt_entry_reg[1] <= peb_pkg::RST_ADAPT_ENTRY1;
      adapt_entry_reg[2] <= peb_pkg::RST_ADAPT_ENTRY2;
      adapt_entry_reg[3] <= peb_pkg::RST_ADAPT_ENTRY3;
    end else if (wr_entry_hit) begin
      adapt_entry_reg[wr_entry_idx] <= REG_WDATA;
    end
  end

  // Read mux; read-only reserved registers return constants
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = peb_pkg::RDATA_UNMAPPED;
    unique case (REG_ADDR)
      peb_pkg::ADDR_RSVD_RO_A: rd_mux = peb_pkg::RST_RSVD_RO_A;
      peb_pkg::ADDR_LOW_RATE_BOOST: rd_mux = low_rate_boost_reg;
      peb_pkg::ADDR_RSVD_RO_B: rd_mux = peb_pkg::RST_RSVD_RO_B;
      peb_pkg::ADDR_RSVD_RO_C: rd_mux = peb_pkg::RST_RSVD_RO_C;
      peb_pkg::ADDR_RSVD_RW_D: rd_mux = rsvd_rw_d_reg;
      peb_pkg::ADDR_EYE_LOCK_MON: rd_mux = eye_lock_mon_reg;
      peb_pkg::ADDR_STRAP_OVERRIDE: rd_mux = strap_override_reg;
      peb_pkg::ADDR_ADAPT_ENTRY0: rd_mux = adapt_entry_reg[0];
      peb_pkg::ADDR_ADAPT_ENTRY1: rd_mux = adapt_entry_reg[1];
      peb_pkg::ADDR_ADAPT_ENTRY2: rd_mux = adapt_entry_reg[2];
      peb_pkg::ADDR_ADAPT_ENTRY3: rd_mux = adapt_entry_reg[3];
      default: rd_mux = peb_pkg::RDATA_UNMAPPED;
    endcase
  end

  // Registered read answer
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= REG_RD;
      if (REG_RD) rdata_reg <= rd_mux;
    end
  end

  // Strap or register source selection
  // Strap codes arrive two edges after the pins move
  wire [1:0] route_code = insel_bypass ? EXT_FIELDS.route_sel : insel_pin;
  wire [1:0] out_mux_sel = outmux_bypass ? EXT_FIELDS.out_mux : outctrl_pin;
  wire [1:0] strap_ref_rate = (insel_pin == peb_pkg::STRAP_INSEL_10GBE) ? peb_pkg::REFRATE_10GBE
                                                                         : peb_pkg::REFRATE_VIDEO;
  wire [1:0] ref_rate_sel = refrate_bypass ? EXT_FIELDS.ref_rate : strap_ref_rate;
  wire ref_rate_bad = (ref_rate_sel != peb_pkg::REFRATE_VIDEO) &&
                      (ref_rate_sel != peb_pkg::REFRATE_10GBE);
  wire strap_bypass = (outctrl_pin == peb_pkg::STRAP_OUTCTRL_BYPASS);
  wire bypass_sel = boost_bypass_ov ? EXT_FIELDS.boost_ov_en : strap_bypass;

  // Route decode
  // Source and output enables per route code
  logic out0_on;
  logic out1_on;
  logic src_second;
  always_comb begin
    out0_on = 1'b1;
    out1_on = 1'b1;
    src_second = 1'b0;
    unique case (route_code)
      peb_pkg::ROUTE_FIRST_BOTH: begin
        out0_on = 1'b1;
        out1_on = 1'b1;
        src_second = 1'b0;
      end
      peb_pkg::ROUTE_FIRST_OUT0: begin
        out0_on = 1'b1;
        out1_on = 1'b0;
        src_second = 1'b0;
      end
      peb_pkg::ROUTE_SECOND_OUT1: begin
        out0_on = 1'b0;
        out1_on = 1'b1;
        src_second = 1'b1;
      end
      peb_pkg::ROUTE_SECOND_BOTH: begin
        out0_on = 1'b1;
        out1_on = 1'b1;
        src_second = 1'b1;
      end
    endcase
  end

  // Adaptation request: register mode field or automatic on selection
  wire mode_auto = (EXT_FIELDS.adapt_mode == peb_pkg::MODE_AUTO);
  wire adapt_req = adapt_bypass ? mode_auto : src_second;
  wire low_rate = (RATE_DETECT == peb_pkg::RATE_270M) || (RATE_DETECT == peb_pkg::RATE_1G5);
  wire mid_rate_fixed = (RATE_DETECT == peb_pkg::RATE_3G) && !mid_rate_adapt;
  wire use_fixed = low_rate || mid_rate_fixed;
  wire adapt_active = adapt_req && !use_fixed && !bypass_sel;

  // Control output assembly
  always_comb begin
    ctrl_next.out0_on = out0_on;
    ctrl_next.out1_on = out1_on;
    ctrl_next.src_second = src_second;
    ctrl_next.out_mux = out_mux_sel;
    ctrl_next.ref_rate = ref_rate_sel;
    ctrl_next.ref_rate_invalid = ref_rate_bad;
    ctrl_next.adapt_en = adapt_active;
    ctrl_next.boost_bypass = bypass_sel;
  end

  // Boost word selection; byte maps straight onto stage fields
  // With no source chosen, table entry 0 stays on the stages
  always_comb begin
    if (bypass_sel) begin
      boost_next = peb_pkg::peb_boost_t'(EXT_FIELDS.boost_word);
    end else if (use_fixed) begin
      boost_next = peb_pkg::peb_boost_t'(low_rate_boost_reg);
    end else if (adapt_active) begin
      boost_next = peb_pkg::peb_boost_t'(adapt_entry_reg[ADAPT_INDEX]);
    end else begin
      boost_next = peb_pkg::peb_boost_t'(adapt_entry_reg[0]);
    end
  end

  // Output control registers
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= '0;
      boost_reg <= '0;
    end else begin
      ctrl_reg <= ctrl_next;
      boost_reg <= boost_next;
    end
  end

  // Eye monitor interval length
  wire eye_ready = mon_enable && LOCK_DONE && ADAPT_DONE;
  // Shift by the interval field; 32 bits hold the longest interval
  wire [31:0] eye_limit = 32'(EYE_BASE_CYCLES) << EXT_FIELDS.eye_interval;

  // Eye monitor sequencing
  always_comb begin
    eye_state_next = eye_state_reg;
    eye_cnt_next = eye_cnt_reg;
    unique case (eye_state_reg)
      EYE_IDLE: begin
        eye_cnt_next = 32'h0000_0000;
        if (eye_ready) eye_state_next = EYE_COUNT;
      end
      EYE_COUNT: begin
        if (!eye_ready) begin
          eye_state_next = EYE_IDLE;
        end else if (eye_cnt_reg >= eye_limit - 32'h0000_0001) begin
          eye_state_next = EYE_FIRE;
        end else begin
          eye_cnt_next = eye_cnt_reg + 32'h0000_0001;
        end
      end
      EYE_FIRE: begin
        // The firing cycle is the first cycle of the next interval
        eye_cnt_next = 32'h0000_0001;
        eye_state_next = eye_ready ? EYE_COUNT : EYE_IDLE;
      end
      // Unused state code falls back to idle
      default: begin
        eye_state_next = EYE_IDLE;
        eye_cnt_next = 32'h0000_0000;
      end
    endcase
  end

  // Eye monitor state and pulse
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      eye_state_reg <= EYE_IDLE;
      eye_cnt_reg <= 32'h0000_0000;
      eye_pulse_reg <= 1'b0;
      mon_active_reg <= 1'b0;
    end else begin
      eye_state_reg <= eye_state_next;
      eye_cnt_reg <= eye_cnt_next;
      eye_pulse_reg <= (eye_state_next == EYE_FIRE);
      mon_active_reg <= (eye_state_next != EYE_IDLE);
    end
  end

  // Outputs straight from flip-flops
  assign REG_RDATA = rdata_reg;
  assign REG_RVALID = rvalid_reg;
  assign CTRL_OUT = ctrl_reg;
  assign BOOST_STAGES = boost_reg;
  assign EYE_EVAL_PULSE = eye_pulse_reg;
  assign MONITOR_ACTIVE = mon_active_reg;

endmodule

// [sim/peb_monitor.sv]
// Checker for the strap override and boost register slice, bound to peb_top.
// Assumes the top module's ports only; shadows the steering registers from the write strobe.
`timescale 1ns/1ps
module peb_monitor (
  input wire logic CLK, // Device clock
  input wire logic RSTN, // Async reset, active low
  input wire logic [7:0] REG_ADDR, // Register address
  input wire logic REG_WR, // Write strobe
  input wire logic REG_RD, // Read strobe
  input wire logic [7:0] REG_WDATA, // Write data
  input wire logic [7:0] REG_RDATA, // Read data
  input wire logic REG_RVALID, // Read data valid
  input wire peb_pkg::peb_ext_t EXT_FIELDS, // Neighbouring fields
  input wire peb_pkg::peb_rate_t RATE_DETECT, // Detected rate
  input wire logic LOCK_DONE, // Locked
  input wire logic ADAPT_DONE, // Adaptation finished
  input wire peb_pkg::peb_ctrl_t CTRL_OUT, // Resolved controls
  input wire peb_pkg::peb_boost_t BOOST_STAGES, // Equalizer stages
  input wire logic EYE_EVAL_PULSE, // Eye evaluation request
  input wire logic MONITOR_ACTIVE // Eye monitor running
);
  logic [7:0] ov_reg;
  logic [7:0] fix_reg;
  logic mon_reg;
  // Shadows of the override, fixed boost and monitor enable registers
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ov_reg <= 8'h01;
      fix_reg <= 8'h00;
      mon_reg <= 1'b1;
    end else if (REG_WR) begin
      if (REG_ADDR == 8'h3F) ov_reg <= REG_WDATA;
      if (REG_ADDR == 8'h3A) fix_reg <= REG_WDATA;
      if (REG_ADDR == 8'h3E) mon_reg <= REG_WDATA[7];
    end
  end
  // Conditions that fix the boost source
  wire rdy = mon_reg & LOCK_DONE & ADAPT_DONE;
  wire slow = (RATE_DETECT == peb_pkg::RATE_270M) | (RATE_DETECT == peb_pkg::RATE_1G5);
  wire mid = (RATE_DETECT == peb_pkg::RATE_3G) & ~ov_reg[0];
  wire fixed_sel = ov_reg[1] & ~EXT_FIELDS.boost_ov_en & (slow | mid);
  wire byp_sel = ov_reg[1] & EXT_FIELDS.boost_ov_en;
  wire rte = ov_reg[4];
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence s_unready;
    !rdy [*3];
  endsequence
  sequence s_read_ro;
    REG_RD && REG_ADDR == 8'h3B;
  endsequence
  a_read_answer: assert property (REG_RD |=> REG_RVALID) else $error("read not answered");
  a_answer_cause: assert property (REG_RVALID |-> $past(REG_RD)) else $error("stray read valid");
  a_ro_value: assert property (s_read_ro |=> REG_RVALID && REG_RDATA == 8'h96) else $error("ro value");
  a_route_src: assert property ($past(rte) |-> CTRL_OUT.src_second == $past(EXT_FIELDS.route_sel[1]))
    else $error("route source");
  a_route_outs: assert property ($past(rte) |-> CTRL_OUT.out0_on == ($past(EXT_FIELDS.route_sel) != 2'h2)
    && CTRL_OUT.out1_on == ($past(EXT_FIELDS.route_sel) != 2'h1)) else $error("route outputs");
  a_mux_follow: assert property ($past(ov_reg[3]) |-> CTRL_OUT.out_mux == $past(EXT_FIELDS.out_mux))
    else $error("output mux");
  a_rate_follow: assert property ($past(ov_reg[2]) |-> CTRL_OUT.ref_rate == $past(EXT_FIELDS.ref_rate)
    && CTRL_OUT.ref_rate_invalid == $past(EXT_FIELDS.ref_rate[1])) else $error("reference rate");
  a_fixed_boost: assert property ($past(fixed_sel) |-> BOOST_STAGES == $past(fix_reg))
    else $error("fixed boost");
  a_bypass_word: assert property ($past(byp_sel) |-> BOOST_STAGES == $past(EXT_FIELDS.boost_word)
    && CTRL_OUT.boost_bypass) else $error("boost bypass");
  a_eye_idle: assert property (s_unready |-> !MONITOR_ACTIVE && !EYE_EVAL_PULSE) else $error("eye idle");
  a_eye_gap: assert property (EYE_EVAL_PULSE |=> !EYE_EVAL_PULSE [*3]) else $error("eye spacing");
endmodule
bind peb_top peb_monitor u_mon (.CLK(CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .EXT_FIELDS(EXT_FIELDS), .RATE_DETECT(RATE_DETECT), .LOCK_DONE(LOCK_DONE), .ADAPT_DONE(ADAPT_DONE),
  .CTRL_OUT(CTRL_OUT), .BOOST_STAGES(BOOST_STAGES), .EYE_EVAL_PULSE(EYE_EVAL_PULSE),
  .MONITOR_ACTIVE(MONITOR_ACTIVE));

// [sim/peb_host.sv]
// Host model that drives the byte register port.
// Assumes requests launch on the falling edge and are taken on the next rising edge.
`timescale 1ns/1ps
module peb_host (
  input wire logic CLK, // Device clock
  output logic [7:0] REG_ADDR, // Register address
  output logic REG_WR, // Write strobe
  output logic REG_RD, // Read strobe
  output logic [7:0] REG_WDATA, // Write data
  input wire logic [7:0] REG_RDATA, // Read data
  input wire logic REG_RVALID // Read data valid
);
  // Idle bus from time zero
  initial begin
    REG_ADDR = 8'h00;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_WDATA = 8'h00;
  end
  // One write; released lines carry the inverse so stale values never pass
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge CLK);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WR = 1'b1;
    @(negedge CLK);
    REG_WR = 1'b0;
    REG_ADDR = ~a;
    REG_WDATA = ~d;
  endtask
  // One read; data and valid taken on the falling edge half a cycle after the read edge
  task rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge CLK);
    REG_ADDR = a;
    REG_RD = 1'b1;
    @(negedge CLK);
    REG_RD = 1'b0;
    REG_ADDR = ~a;
    ok = REG_RVALID;
    d = REG_RDATA;
  endtask
endmodule

// [sim/test_pin_override_eq_boost_regs.sv]
// Self-checking bench for peb_top with a shortened eye interval base.
// Assumes peb_host drives the register port; all other inputs change on the falling edge.
`timescale 1ns/1ps
module test_pin_override_eq_boost_regs;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr, wdata, rdata, got;
  logic wr, rd, rvalid, eye_pulse, mon_act, ok;
  logic [1:0] sel_pin = 2'h0;
  logic [1:0] ctl_pin = 2'h0;
  logic lock = 1'b0;
  logic adone = 1'b0;
  logic [1:0] aidx = 2'h0;
  peb_pkg::peb_ext_t ext = '0;
  peb_pkg::peb_rate_t rate = peb_pkg::RATE_NONE;
  peb_pkg::peb_ctrl_t ctrl;
  peb_pkg::peb_boost_t bst;
  int bad_count = 0;
  int total_checks = 0;
  int n;
  logic [7:0] rst_v [11] = '{8'h00, 8'h00, 8'h96, 8'h90, 8'h00, 8'h80, 8'h01, 8'h00, 8'h40, 8'h80, 8'h50};
  // Bits the host may change; reserved bits are written with their reset value
  logic [7:0] rw_m [11] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h80, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  // Read-modify-write value for slice place i
  function automatic logic [7:0] rw_v(input int i);
    return ((8'h5A + 8'(i)) & rw_m[i]) | (rst_v[i] & ~rw_m[i]);
  endfunction
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Block and host
  peb_top #(.EYE_BASE_CYCLES(4)) dut (.CLK(clk), .RSTN(rstn), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid), .IN_OUT_SEL_PIN(sel_pin),
    .OUT_CTRL_PIN(ctl_pin), .EXT_FIELDS(ext), .RATE_DETECT(rate), .LOCK_DONE(lock), .ADAPT_DONE(adone),
    .ADAPT_INDEX(aidx), .CTRL_OUT(ctrl), .BOOST_STAGES(bst), .EYE_EVAL_PULSE(eye_pulse),
    .MONITOR_ACTIVE(mon_act));
  peb_host host (.CLK(clk), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata),
    .REG_RDATA(rdata), .REG_RVALID(rvalid));
  // Comparison and reporting
  task chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, got, ok);
    chk("read valid", 8'h01, {7'h00, ok});
    chk("read data", exp, got);
  endtask
  task settle;
    repeat (5) @(negedge clk);
  endtask
  task results;
    if (bad_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Reset values of the slice and an unmapped address
  task t_reset_vals;
    for (int i = 0; i < 11; i++) rdchk(8'h39 + 8'(i), rst_v[i]);
    rdchk(8'h50, 8'h00);
  endtask
  // Writes to writable places only, reserved bits preserved; read all back
  task t_rw;
    for (int i = 0; i < 11; i++) if (rw_m[i] != 8'h00) host.wr(8'h39 + 8'(i), rw_v(i));
    for (int i = 0; i < 11; i++) rdchk(8'h39 + 8'(i), rw_v(i));
  endtask
  // Fixed word, table entries and bypass word into the equalizer
  task t_boost;
    host.wr(8'h3A, 8'h1B);
    host.wr(8'h3F, 8'h02);
    rate = peb_pkg::RATE_270M;
    settle;
    chk("stage3", 8'h03, {6'h00, bst.stage3});
    chk("stage0", 8'h00, {6'h00, bst.stage0});
    rate = peb_pkg::RATE_1G5;
    settle;
    chk("boost 1g5", 8'h1B, bst);
    rate = peb_pkg::RATE_3G;
    settle;
    chk("boost 3g", 8'h1B, bst);
    host.wr(8'h3F, 8'h21);
    ext.adapt_mode = peb_pkg::MODE_AUTO;
    for (int i = 0; i < 4; i++) begin
      aidx = 2'(i);
      settle;
      chk("entry", rst_v[7 + i], bst);
      chk("adapt on", 8'h01, {7'h00, ctrl.adapt_en});
    end
    ext.adapt_mode = peb_pkg::MODE_MANUAL;
    settle;
    chk("adapt off", 8'h00, {7'h00, ctrl.adapt_en});
    host.wr(8'h3F, 8'h02);
    ext.boost_ov_en = 1'b1;
    ext.boost_word = 8'hC6;
    settle;
    chk("bypass word", 8'hC6, bst);
    chk("bypass", 8'h01, {7'h00, ctrl.boost_bypass});
    ext.boost_ov_en = 1'b0;
  endtask
  // Route by register field, then by strap
  task t_route;
    host.wr(8'h3F, 8'h10);
    for (int r = 0; r < 4; r++) begin
      ext.route_sel = 2'(r);
      settle;
      chk("out0", {7'h00, r != 2}, {7'h00, ctrl.out0_on});
      chk("out1", {7'h00, r != 1}, {7'h00, ctrl.out1_on});
      chk("source", {7'h00, r > 1}, {7'h00, ctrl.src_second});
    end
    host.wr(8'h3F, 8'h01);
    for (int r = 0; r < 4; r++) begin
      sel_pin = 2'(r);
      ext.route_sel = ~2'(r);
      settle;
      chk("strap source", {7'h00, r > 1}, {7'h00, ctrl.src_second});
      chk("strap rate", (r == 3) ? 8'h01 : 8'h00, {6'h00, ctrl.ref_rate});
      chk("auto adapt", {7'h00, r > 1}, {7'h00, ctrl.adapt_en});
    end
  endtask
  // Output mux and reference rate by register, then output mux and boost bypass by strap
  task t_mux_rate;
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h3F, 8'h0C);
      ext.out_mux = 2'(c);
      ext.ref_rate = 2'(c);
      ctl_pin = ~2'(c);
      settle;
      chk("mux", 8'(c), {6'h00, ctrl.out_mux});
      chk("rate", 8'(c), {6'h00, ctrl.ref_rate});
      chk("rate invalid", {7'h00, c > 1}, {7'h00, ctrl.ref_rate_invalid});
      host.wr(8'h3F, 8'h01);
      ctl_pin = 2'(c);
      settle;
      chk("strap mux", 8'(c), {6'h00, ctrl.out_mux});
      chk("strap bypass", {7'h00, c == 3}, {7'h00, ctrl.boost_bypass});
    end
  endtask
  // Bounded wait for the next eye pulse
  task wait_pulse;
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n > 200) begin
        bad_count++;
        results;
      end
    end while (eye_pulse !== 1'b1);
  endtask
  // Eye evaluation period, then disabled monitor
  task t_eye;
    ext.eye_interval = 4'h1;
    lock = 1'b1;
    adone = 1'b1;
    wait_pulse;
    wait_pulse;
    chk("eye period", 8'h08, 8'(n));
    chk("monitor on", 8'h01, {7'h00, mon_act});
    host.wr(8'h3E, 8'h00);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      if (eye_pulse !== 1'b0) n++;
    end
    chk("eye pulses off", 8'h00, 8'(n));
    chk("monitor off", 8'h00, {7'h00, mon_act});
    host.wr(8'h3E, 8'h80);
    lock = 1'b0;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_reset_vals;
    t_boost;
    t_route;
    t_mux_rate;
    t_eye;
    t_rw;
    results;
  end
endmodule
